// ### rtl/cam_regs.svh
// constants for the cpu address mode decoder: prefix codes, reset values
// assumes it is included by bare name from the condition evaluator and the decoder
// What this block does
// - indexed address is unsigned sum of index register and offset
// - no-offset indexed takes no extra byte; address is index, page zero
// - short indexed fetches one offset byte; sum reaches 1FE, no wrap
// - long indexed fetches a two-byte offset, reaching all 64 Kbyte
// - short indirect reads a byte pointer from a page-zero address byte
// - long indirect reads a word pointer from a page-zero address byte
// - indirect indexed adds index to the pointer read from memory
// - short form uses byte pointer up to 1FE; long form word pointer
// - relative forms add a sign-extended 8-bit offset to the pc
// - relative direct offset follows opcode; indirect reads it from memory
// - short-only instruction classes refuse every long addressing form
// - prefix 90 makes an x form use the y register
// - prefix 92 turns direct, relative and bit forms into indirect, except bit test and jump
// - prefix 92 turns x indexed into indirect x indexed
// - prefix 91 turns x indexed into y indirect indexed
// - instruction is optional prefix, opcode, then zero to two bytes
// - conditional jumps test half carry, mask level, n, z, c or c|z
// - two jumps test the external interrupt pin high or low
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

`define CAM_PFX_Y      8'h90
`define CAM_PFX_IYI    8'h91
`define CAM_PFX_IND    8'h92
`define CAM_PAGE0      8'h00
`define CAM_MASK_LVL3  2'h3
`define CAM_RST_WORD   16'h0000
`define CAM_RST_BYTE   8'h00

`endif

// ### rtl/cam_pkg.sv
// types shared by the address mode decoder and its condition evaluator
// assumes nothing beyond a systemverilog compiler
package cam_pkg;

    // addressing mode as the opcode table gives it, and after prefixes
    typedef enum logic [3:0] {
        M_INH   = 4'h0, M_IMM   = 4'h1, M_DIR_S = 4'h2, M_DIR_L = 4'h3,
        M_IDX0  = 4'h4, M_IDX_S = 4'h5, M_IDX_L = 4'h6, M_IND_S = 4'h7,
        M_IND_L = 4'h8, M_IIX_S = 4'h9, M_IIX_L = 4'hA, M_REL_D = 4'hB,
        M_REL_I = 4'hC, M_BIT_D = 4'hD, M_BIT_I = 4'hE, M_BTJ_D = 4'hF
    } cam_mode_t;

    // branch condition of a relative jump
    typedef enum logic [3:0] {
        C_ALWAYS       = 4'h0, C_NEVER      = 4'h1,
        C_HALF_SET     = 4'h2, C_HALF_CLR   = 4'h3,
        C_MASK_LVL3    = 4'h4, C_NOT_LVL3   = 4'h5,
        C_NEG_SET      = 4'h6, C_NEG_CLR    = 4'h7,
        C_ZERO_SET     = 4'h8, C_ZERO_CLR   = 4'h9,
        C_CARRY_SET    = 4'hA, C_CARRY_CLR  = 4'hB,
        C_UNS_GREATER  = 4'hC, C_UNS_LE     = 4'hD,
        C_IRQ_HIGH     = 4'hE, C_IRQ_LOW    = 4'hF
    } cam_cond_t;

    typedef enum logic [1:0] {
        P_NONE = 2'h0, P_Y = 2'h1, P_IND = 2'h2, P_IYI = 2'h3
    } cam_pfx_t;

    // gray along idle -> prefix -> operands -> pointer -> done
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_OPC = 3'b001, S_OPR = 3'b011,
        S_PTR  = 3'b010, S_DONE = 3'b110
    } cam_state_t;

endpackage : cam_pkg

// ### rtl/cam_cond_if.sv
// carrier between the decoder and its branch condition evaluator
// assumes cam_pkg is compiled first
`timescale 1ns/1ns
interface cam_cond_if;
    import cam_pkg::*;
    cam_cond_t  cond;
    logic       half_carry;
    logic       negative;
    logic       zero;
    logic       carry;
    logic [1:0] interrupt_mask_level;
    logic       irq_pin;
    logic       taken;

    modport eval (input cond, half_carry, negative, zero, carry,
                  input interrupt_mask_level, irq_pin, output taken);
    modport user (output cond, half_carry, negative, zero, carry,
                  output interrupt_mask_level, irq_pin, input taken);
endinterface : cam_cond_if

// ### rtl/cam_cond.sv
// branch condition evaluator for the relative jump family
// assumes flags are stable while the decoder samples taken
`timescale 1ns/1ns
`include "cam_regs.svh"
module cam_cond
    import cam_pkg::*;
(
    // condition and flags in, decision out
    cam_cond_if.eval bus
);

    logic lvl3;

    // mask level 3 means both mask bits set
    assign lvl3 = (bus.interrupt_mask_level == `CAM_MASK_LVL3);

    // pure decode; the decoder registers the result
    always_comb begin
        case (bus.cond)
            C_ALWAYS:      bus.taken = 1'b1;
            C_NEVER:       bus.taken = 1'b0;
            C_HALF_SET:    bus.taken = bus.half_carry;
            C_HALF_CLR:    bus.taken = ~bus.half_carry;
            C_MASK_LVL3:   bus.taken = lvl3;
            C_NOT_LVL3:    bus.taken = ~lvl3;
            C_NEG_SET:     bus.taken = bus.negative;
            C_NEG_CLR:     bus.taken = ~bus.negative;
            C_ZERO_SET:    bus.taken = bus.zero;
            C_ZERO_CLR:    bus.taken = ~bus.zero;
            C_CARRY_SET:   bus.taken = bus.carry;
            C_CARRY_CLR:   bus.taken = ~bus.carry;
            C_UNS_GREATER: bus.taken = ~(bus.carry | bus.zero);
            C_UNS_LE:      bus.taken = bus.carry | bus.zero;
            C_IRQ_HIGH:    bus.taken = bus.irq_pin;
            C_IRQ_LOW:     bus.taken = ~bus.irq_pin;
            default:       bus.taken = 1'b0;
        endcase
    end

endmodule : cam_cond

// ### rtl/cam_decoder.sv
// address mode decoder: prefix handling, operand byte collection,
// pointer reads and effective address / branch target formation
// assumes the opcode table presents mode, class and condition with the
// opcode byte, and that pc_in holds the address after the instruction
`timescale 1ns/1ns
`include "cam_regs.svh"
module cam_decoder
    import cam_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    // instruction byte stream from fetch
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    output logic             byte_ready_out,
    // opcode class, valid alongside the opcode byte
    input  wire cam_mode_t   mode_in,
    input  wire logic        short_only_in,
    input  wire cam_cond_t   cond_in,
    // cpu state
    input  wire logic [7:0]  x_reg_in,
    input  wire logic [7:0]  y_reg_in,
    input  wire logic [15:0] pc_in,
    input  wire logic        half_carry_in,
    input  wire logic        negative_in,
    input  wire logic        zero_in,
    input  wire logic        carry_in,
    input  wire logic [1:0]  interrupt_mask_level_in,
    input  wire logic        irq_pin_in,
    // pointer read port
    output logic             mem_req_out,
    output logic [15:0]      mem_addr_out,
    input  wire logic        mem_ack_in,
    input  wire logic [7:0]  mem_rdata_in,
    // results
    output logic             ea_valid_out,
    output logic [15:0]      ea_out,
    output cam_mode_t        mode_out,
    output logic             index_y_out,
    output logic             illegal_out,
    output logic             branch_out,
    output logic             branch_taken_out,
    output logic [15:0]      target_out
);

    // classify an incoming byte as one of the three prefixes
    function automatic cam_pfx_t pfx_kind(input logic [7:0] b);
        case (b)
            `CAM_PFX_Y:   pfx_kind = P_Y;
            `CAM_PFX_IYI: pfx_kind = P_IYI;
            `CAM_PFX_IND: pfx_kind = P_IND;
            default:      pfx_kind = P_NONE;
        endcase
    endfunction : pfx_kind

    // mode after the prefix has been applied
    function automatic cam_mode_t apply_pfx(input cam_mode_t m,
                                            input cam_pfx_t p);
        apply_pfx = m;
        if (p == P_IND) begin
            case (m)
                M_DIR_S: apply_pfx = M_IND_S;
                M_DIR_L: apply_pfx = M_IND_L;
                M_REL_D: apply_pfx = M_REL_I;
                M_BIT_D: apply_pfx = M_BIT_I;
                M_IDX_S: apply_pfx = M_IIX_S;
                M_IDX_L: apply_pfx = M_IIX_L;
                default: apply_pfx = m;
            endcase
        end else if (p == P_IYI) begin
            case (m)
                M_IDX_S: apply_pfx = M_IIX_S;
                M_IDX_L: apply_pfx = M_IIX_L;
                default: apply_pfx = m;
            endcase
        end
    endfunction : apply_pfx

    // y replaces x for plain x forms under 90, indirect indexed under 91
    function automatic logic pfx_y(input cam_mode_t m, input cam_pfx_t p);
        case (p)
            P_Y:     pfx_y = (m == M_INH) || (m == M_IMM) || (m == M_DIR_S)
                          || (m == M_DIR_L) || (m == M_IDX0)
                          || (m == M_IDX_S) || (m == M_IDX_L);
            P_IYI:   pfx_y = (m == M_IDX_S) || (m == M_IDX_L);
            default: pfx_y = 1'b0;
        endcase
    endfunction : pfx_y

    // bytes that follow the opcode
    function automatic logic [1:0] opr_need(input cam_mode_t m);
        case (m)
            M_INH, M_IDX0:          opr_need = 2'd0;
            M_DIR_L, M_IDX_L,
            M_BTJ_D:                opr_need = 2'd2;
            default:                opr_need = 2'd1;
        endcase
    endfunction : opr_need

    // pointer bytes read from memory
    function automatic logic [1:0] ptr_need(input cam_mode_t m);
        case (m)
            M_IND_S, M_IIX_S,
            M_REL_I, M_BIT_I:       ptr_need = 2'd1;
            M_IND_L, M_IIX_L:       ptr_need = 2'd2;
            default:                ptr_need = 2'd0;
        endcase
    endfunction : ptr_need

    function automatic logic is_long(input cam_mode_t m);
        is_long = (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L)
               || (m == M_IIX_L);
    endfunction : is_long

    function automatic logic is_branch(input cam_mode_t m);
        is_branch = (m == M_REL_D) || (m == M_REL_I) || (m == M_BTJ_D);
    endfunction : is_branch

    // zero-extended sum, so short forms reach 1FE without wrapping
    function automatic logic [15:0] add_idx(input logic [15:0] base,
                                            input logic [7:0]  idx);
        add_idx = base + {`CAM_PAGE0, idx};
    endfunction : add_idx

    // pc plus sign-extended offset
    function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                               input logic [7:0]  off);
        rel_target = pc + {{8{off[7]}}, off};
    endfunction : rel_target

    function automatic logic takes_bytes(input cam_state_t s);
        takes_bytes = (s == S_IDLE) || (s == S_OPC) || (s == S_OPR);
    endfunction : takes_bytes

    // reset release through two flops
    logic rst_meta_n_ff;
    logic rst_n_ff;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_n_ff <= 1'b0;
            rst_n_ff      <= 1'b0;
        end else begin
            rst_meta_n_ff <= 1'b1;
            rst_n_ff      <= rst_meta_n_ff;
        end
    end

    cam_state_t  state_ff;
    cam_state_t  nxt_state;
    cam_pfx_t    pfx_ff;
    cam_mode_t   mode_ff;
    cam_mode_t   eff_mode;
    cam_cond_t   cond_ff;
    logic        use_y_ff;
    logic        bad_ff;
    logic        bad;
    logic [1:0]  left_ff;
    logic [1:0]  ptr_left_ff;
    logic [15:0] opr_ff;
    logic [15:0] nxt_opr;
    logic [15:0] ptr_ff;
    logic        byte_ready_ff;
    logic        take;
    logic        op_take;
    logic        is_pfx;
    logic [7:0]  idx;
    cam_cond_if  cbus ();

    // condition evaluator sees the latched condition and live flags
    cam_cond u_cond (
        .bus (cbus.eval)
    );

    assign cbus.cond                 = cond_ff;
    assign cbus.half_carry           = half_carry_in;
    assign cbus.negative             = negative_in;
    assign cbus.zero                 = zero_in;
    assign cbus.carry                = carry_in;
    assign cbus.interrupt_mask_level = interrupt_mask_level_in;
    assign cbus.irq_pin              = irq_pin_in;

    // byte handshake and opcode recognition
    assign take     = byte_valid_in & byte_ready_ff;
    assign is_pfx   = (pfx_kind(byte_in) != P_NONE);
    assign op_take  = take & ~is_pfx & ((state_ff == S_IDLE)
                    | (state_ff == S_OPC));
    assign eff_mode = apply_pfx(mode_in, pfx_ff);
    assign bad      = short_only_in & is_long(eff_mode);
    assign idx      = use_y_ff ? y_reg_in : x_reg_in;
    // high byte comes first, so each new byte shifts in at the bottom
    assign nxt_opr  = {opr_ff[7:0], byte_in};
    // ready leaves straight from its flop, no decode on the port
    assign byte_ready_out = byte_ready_ff;

    // next state; a refused opcode still passes through done once
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE, S_OPC: begin
                if (take && is_pfx) begin
                    nxt_state = S_OPC;      // a repeated prefix replaces
                end else if (op_take) begin
                    if (bad || opr_need(eff_mode) == 2'd0) begin
                        nxt_state = S_DONE;
                    end else begin
                        nxt_state = S_OPR;
                    end
                end
            end
            S_OPR: begin
                if (take && left_ff == 2'd1) begin
                    nxt_state = (ptr_need(mode_ff) != 2'd0) ? S_PTR : S_DONE;
                end
            end
            S_PTR: begin
                if (mem_ack_in && ptr_left_ff == 2'd1) begin
                    nxt_state = S_DONE;
                end
            end
            S_DONE:  nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    // state and byte ready, the latter registered from the next state
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff      <= S_IDLE;
            byte_ready_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            byte_ready_ff <= takes_bytes(nxt_state);
        end
    end

    // prefix lives until the instruction it modifies is finished
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pfx_ff <= P_NONE;
        end else if (take && is_pfx && state_ff != S_OPR) begin
            pfx_ff <= pfx_kind(byte_in);
        end else if (state_ff == S_DONE) begin
            pfx_ff <= P_NONE;
        end
    end

    // opcode class captured with the opcode byte
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mode_ff  <= M_INH;
            cond_ff  <= C_NEVER;
            use_y_ff <= 1'b0;
            bad_ff   <= 1'b0;
        end else if (op_take) begin
            mode_ff  <= eff_mode;
            cond_ff  <= cond_in;
            use_y_ff <= pfx_y(mode_in, pfx_ff);
            bad_ff   <= bad;
        end
    end

    // operand bytes after the opcode, zero to two of them
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            opr_ff  <= `CAM_RST_WORD;
            left_ff <= 2'd0;
        end else if (op_take) begin
            opr_ff  <= `CAM_RST_WORD;
            left_ff <= opr_need(eff_mode);
        end else if (state_ff == S_OPR && take) begin
            opr_ff  <= nxt_opr;
            left_ff <= left_ff - 2'd1;
        end
    end

    // pointer reads from page zero; word pointers take the next address
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mem_req_out  <= 1'b0;
            mem_addr_out <= `CAM_RST_WORD;
            ptr_left_ff  <= 2'd0;
            ptr_ff       <= `CAM_RST_WORD;
        end else if (state_ff == S_OPR && nxt_state == S_PTR) begin
            mem_req_out  <= 1'b1;
            mem_addr_out <= {`CAM_PAGE0, nxt_opr[7:0]};
            ptr_left_ff  <= ptr_need(mode_ff);
            ptr_ff       <= `CAM_RST_WORD;
        end else if (state_ff == S_PTR && mem_ack_in) begin
            ptr_ff       <= {ptr_ff[7:0], mem_rdata_in};
            mem_addr_out <= mem_addr_out + 16'h0001;
            ptr_left_ff  <= ptr_left_ff - 2'd1;
            mem_req_out  <= (ptr_left_ff != 2'd1);
        end
    end

    // effective address and branch target, formed in the done cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ea_out      <= `CAM_RST_WORD;
            target_out  <= `CAM_RST_WORD;
            mode_out    <= M_INH;
            index_y_out <= 1'b0;
        end else if (state_ff == S_DONE && !bad_ff) begin
            mode_out    <= mode_ff;
            index_y_out <= use_y_ff;
            target_out  <= pc_in;
            case (mode_ff)
                M_DIR_S, M_BIT_D: ea_out <= {`CAM_PAGE0, opr_ff[7:0]};
                M_DIR_L: ea_out <= opr_ff;
                M_IDX0:  ea_out <= {`CAM_PAGE0, idx};
                M_IDX_S: ea_out <= add_idx({`CAM_PAGE0, opr_ff[7:0]},
                                           idx);
                M_IDX_L: ea_out <= add_idx(opr_ff, idx);
                M_IND_S, M_BIT_I: ea_out <= {`CAM_PAGE0, ptr_ff[7:0]};
                M_IND_L: ea_out <= ptr_ff;
                M_IIX_S: ea_out <= add_idx({`CAM_PAGE0, ptr_ff[7:0]},
                                           idx);
                M_IIX_L: ea_out <= add_idx(ptr_ff, idx);
                M_REL_D: target_out <= rel_target(pc_in, opr_ff[7:0]);
                M_REL_I: target_out <= rel_target(pc_in, ptr_ff[7:0]);
                M_BTJ_D: begin
                    ea_out     <= {`CAM_PAGE0, opr_ff[15:8]};
                    target_out <= rel_target(pc_in, opr_ff[7:0]);
                end
                default: ea_out <= opr_ff;   // immediate and inherent
            endcase
        end
    end

    // one-cycle result strobes
    always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ea_valid_out     <= 1'b0;
            illegal_out      <= 1'b0;
            branch_out       <= 1'b0;
            branch_taken_out <= 1'b0;
        end else begin
            ea_valid_out     <= (state_ff == S_DONE) & ~bad_ff;
            illegal_out      <= (state_ff == S_DONE) & bad_ff;
            branch_out       <= (state_ff == S_DONE) & ~bad_ff
                              & is_branch(mode_ff);
            // flags are taken at the done cycle, after any pointer read
            branch_taken_out <= (state_ff == S_DONE) & ~bad_ff
                              & is_branch(mode_ff) & cbus.taken;
        end
    end

endmodule : cam_decoder

// ### bench/cam_decoder_chk.sv
// port assertions for the address mode decoder: pulses, pointer reads
// assumes cam_pkg is compiled first; bound onto every cam_decoder
`timescale 1ns/1ns
module cam_dec_chk
    import cam_pkg::*;
(
    // watched ports
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic        byte_ready_out,
    input wire logic        mem_req_out,
    input wire logic [15:0] mem_addr_out,
    input wire logic        mem_ack_in,
    input wire logic [15:0] pc_in,
    input wire logic        ea_valid_out,
    input wire logic [15:0] ea_out,
    input wire cam_mode_t   mode_out,
    input wire logic        illegal_out,
    input wire logic        branch_out,
    input wire logic        branch_taken_out,
    input wire logic [15:0] target_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // first byte of a word pointer taken, second read still pending
    sequence word_step;
        mem_req_out && mem_ack_in ##1 mem_req_out;
    endsequence
    // result pulses and their companions
    a_taken_is_branch: assert property (branch_taken_out
        |-> branch_out) else $error("taken without branch");
    a_valid_one_cycle: assert property (ea_valid_out
        |=> !ea_valid_out) else $error("result pulse too long");
    a_illegal_no_ea: assert property (illegal_out |-> !ea_valid_out)
        else $error("long form gave a result");
    a_target_holds_pc: assert property (ea_valid_out && !branch_out
        |-> target_out == $past(pc_in)) else $error("target not pc");
    // address ranges of the short forms
    a_short_idx_range: assert property (ea_valid_out
        && mode_out == M_IDX_S |-> ea_out <= 16'h01FE)
        else $error("short index out of range");
    a_page_zero_ea: assert property (ea_valid_out
        && (mode_out == M_IDX0 || mode_out == M_IND_S)
        |-> ea_out[15:8] == 8'h00)
        else $error("page zero form left page zero");
    // pointer read port: hold, page zero start, address steps by one
    a_req_holds_addr: assert property (mem_req_out && !mem_ack_in
        |=> mem_req_out && $stable(mem_addr_out)) else $error("req dropped");
    a_ptr_page_zero: assert property ($rose(mem_req_out)
        |-> mem_addr_out[15:8] == 8'h00) else $error("pointer not page zero");
    a_word_next_addr: assert property (word_step
        |-> mem_addr_out == $past(mem_addr_out) + 16'h0001)
        else $error("word pointer address not incremented");
    a_ptr_no_ready: assert property (mem_req_out |-> !byte_ready_out)
        else $error("bytes accepted during pointer read");
endmodule : cam_dec_chk

bind cam_decoder cam_dec_chk u_chk (.ref_clk_in, .nrst_in, .byte_ready_out,
    .mem_req_out, .mem_addr_out, .mem_ack_in, .pc_in, .ea_valid_out, .ea_out,
    .mode_out, .illegal_out, .branch_out, .branch_taken_out, .target_out);

// ### bench/testbench.sv
// self-checking bench for the address mode decoder
// assumes cam_pkg, the design and the bound checker are compiled first
`timescale 1ns/1ns
module testbench;
    import cam_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, bv = 1'b0, so = 1'b0, ack = 1'b0;
    logic [7:0]  bt = 8'h00, xr = 8'h00, yr = 8'h00, rd = 8'h00;
    logic [15:0] pc = 16'h0000;
    logic [5:0]  fl = 6'h00;  // half, neg, zero, carry, level3, pin
    cam_mode_t   md = M_INH;
    cam_cond_t   cd = C_ALWAYS;
    logic [7:0]  mem [0:255];
    logic        rdy, req, eav, ydx, ill, br, tk, g_v, g_ill, g_br, g_tk;
    logic [15:0] addr, ea, tgt;
    cam_mode_t   mo;
    int          err_total = 0;
    int          num_checks = 0;

    cam_decoder uut (.ref_clk_in(clk), .nrst_in(nrst), .byte_valid_in(bv),
        .byte_in(bt), .byte_ready_out(rdy), .mode_in(md), .short_only_in(so),
        .cond_in(cd), .x_reg_in(xr), .y_reg_in(yr), .pc_in(pc),
        .half_carry_in(fl[5]), .negative_in(fl[4]), .zero_in(fl[3]),
        .carry_in(fl[2]), .interrupt_mask_level_in({fl[1], 1'b1}),
        .irq_pin_in(fl[0]), .mem_req_out(req), .mem_addr_out(addr),
        .mem_ack_in(ack), .mem_rdata_in(rd), .ea_valid_out(eav), .ea_out(ea),
        .mode_out(mo), .index_y_out(ydx), .illegal_out(ill),
        .branch_out(br), .branch_taken_out(tk), .target_out(tgt));

    always #50 clk = ~clk;

    // pointer memory answers a cycle late; data is scrambled between acks
    always @(negedge clk) begin
        if (req && !ack) begin
            ack <= 1'b1;
            rd  <= mem[addr[7:0]];
        end else begin
            ack <= 1'b0;
            rd  <= ~rd;
        end
    end

    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk16(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic chk1(input string nm, input logic e, g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask : chk1

    // sends n bytes, high byte first, then waits for the result pulse
    task automatic run(input int n, input logic [23:0] bs, input cam_mode_t m);
        int k;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            bv = 1'b1;
            bt = bs[23-8*i -: 8];
            md = m;
            for (k = 0; k < 50 && rdy !== 1'b1; k++) begin
                @(negedge clk);
            end
            @(posedge clk);
        end
        @(negedge clk);
        bv = 1'b0;
        {g_v, g_ill, g_br, g_tk} = 4'h0;
        for (k = 0; k < 40 && g_v !== 1'b1 && g_ill !== 1'b1; k++) begin
            @(negedge clk);
            {g_v, g_ill, g_br, g_tk} = {eav, ill, br, tk};
        end
    endtask : run

    // expected decision, indexed by condition code
    function automatic logic exp_tk(input cam_cond_t c, input logic [5:0] f);
        logic [15:0] t;
        t = {~f[0], f[0], f[2] | f[3], ~(f[2] | f[3]), ~f[2], f[2], ~f[3],
             f[3], ~f[4], f[4], ~f[1], f[1], ~f[5], f[5], 1'b0, 1'b1};
        return t[c];
    endfunction : exp_tk

    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        end_sim();
    end

    initial begin
        logic [5:0] pat [4];
        pat = '{6'h00, 6'h3F, 6'h2A, 6'h15};
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        {mem[8'h40], mem[8'h50], mem[8'h51]} = {8'h77, 8'hAB, 8'hCD};
        {mem[8'h60], mem[8'h70]} = {8'hF0, 8'hFE};
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        xr = 8'hFF;
        run(1, 24'h4F0000, M_IDX0);
        chk16("ea", 16'h00FF, ea);
        so = 1'b1;
        run(2, 24'hEEFF00, M_IDX_S);
        chk16("ea", 16'h01FE, ea);
        run(1, 24'hDE0000, M_IDX_L);
        chk1("illegal", 1'b1, g_ill);
        chk1("ea valid", 1'b0, g_v);
        so = 1'b0;
        xr = 8'h80;
        run(3, 24'hD61234, M_IDX_L);
        chk16("ea", 16'h12B4, ea);
        yr = 8'h05;
        run(3, 24'h90EE10, M_IDX_S);
        chk16("ea", 16'h0015, ea);
        chk1("index y", 1'b1, ydx);
        run(2, 24'hC64000, M_IND_S);
        chk16("ea", 16'h0077, ea);
        run(3, 24'h92B740, M_DIR_S);
        chk16("ea", 16'h0077, ea);
        chk16("mode", {12'h000, M_IND_S}, {12'h000, mo});
        run(2, 24'hC65000, M_IND_L);
        chk16("ea", 16'hABCD, ea);
        xr = 8'h20;
        run(3, 24'h92E660, M_IDX_S);
        chk16("ea", 16'h0110, ea);
        chk16("mode", {12'h000, M_IIX_S}, {12'h000, mo});
        // 91 sits in front of the x indexed opcode, base mode long indexed
        run(3, 24'h91E650, M_IDX_L);
        chk16("ea", 16'hABD2, ea);
        chk16("mode", {12'h000, M_IIX_L}, {12'h000, mo});
        chk1("index y", 1'b1, ydx);
        pc = 16'h0001;
        run(2, 24'h207000, M_REL_I);
        chk16("target", 16'hFFFF, tgt);
        chk1("taken", 1'b1, g_tk);
        pc = 16'h1000;
        // every condition against four flag patterns
        for (int p = 0; p < 4; p++) begin
            fl = pat[p];
            for (int c = 0; c < 16; c++) begin
                cd = cam_cond_t'(c);
                run(2, {8'h20, p[0] ? 8'h7F : 8'h80, 8'h00}, M_REL_D);
                chk1("branch", 1'b1, g_br);
                chk1("taken", exp_tk(cd, fl), g_tk);
                chk16("target", p[0] ? 16'h107F : 16'h0F80, tgt);
            end
        end
        // bit test and jump: bit address first, then the offset
        cd = C_ALWAYS;
        run(3, 24'h723005, M_BTJ_D);
        chk16("ea", 16'h0030, ea);
        chk16("target", 16'h1005, tgt);
        chk1("branch", 1'b1, g_br);
        chk1("taken", 1'b1, g_tk);
        end_sim();
    end
endmodule : testbench
